//--- verilog/lpc_regs.sv
// Purpose: Partner capability, partner address, remote target and datapath control registers
// Assumes: Back-channel link level is asynchronous; other inputs are on sys_clk_i
// Notes:   Summary of operation below; read data valid only in the cycle after the read strobe
//
// Summary of operation
// - CRC enable bit 2 adds CRC, resets one
// - CRC over first eight bytes, sent ninth
// - Bits 1:0 set forward GPIO count
// - Capability freeze bit 7 blocks autoload
// - Frozen capabilities use software written values
// - Bit 5 shows partner self-test request
// - Bit 4 shows single or multi-port partner
// - Bits 3:0 hold partner port number
// - Link up and unfrozen autoloads capability fields
// - Bits 7:1 autoload partner device address
// - Address freeze bit 0 keeps written address
// - Target slots hold 7-bit address, bit0 zero
// - Alias hit forwards with stored physical address
// - Pass-through enable gates forwarding on match
`timescale 1ns/1ps
`include "lpc_defs.svh"

module lpc_regs (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // Register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [7:0]            reg_rdata_o,
  // Back channel
  input  wire logic                  bc_link_i,
  input  wire logic                  bc_cap_valid_i,
  input  wire logic                  bc_selftest_i,
  input  wire logic                  bc_multi_port_i,
  input  wire logic [3:0]            bc_port_num_i,
  input  wire logic                  bc_addr_valid_i,
  input  wire logic [6:0]            bc_partner_addr_i,
  output logic                       bc_link_up_o,
  // Control sequence in and out of the forward channel
  input  wire logic                  cs_valid_i,
  input  wire logic [7:0]            cs_byte_i,
  output logic                       cs_ready_o,
  output logic                       cs_out_valid_o,
  output logic      [7:0]            cs_out_byte_o,
  output logic                       cs_out_crc_o,
  // I2C forwarding
  input  wire logic                  pass_through_i,
  input  wire logic [6:0]            alias_zero_i,
  input  wire logic [6:0]            alias_one_i,
  input  wire logic                  i2c_req_i,
  input  wire logic [6:0]            i2c_addr_i,
  output logic                       i2c_fwd_o,
  output logic      [6:0]            i2c_fwd_addr_o,
  output logic                       i2c_miss_o,
  // Configuration seen by the datapath
  output logic                       ctrl_seq_crc_enable_o,
  output logic      [1:0]            fwd_gpio_count_o,
  output logic                       cap_freeze_o,
  output logic                       partner_selftest_request_o,
  output logic                       partner_multi_port_o,
  output logic      [3:0]            partner_port_num_o,
  output logic      [6:0]            partner_device_address_o,
  output logic                       partner_address_freeze_o
);
  import lpc_pkg::*;

  localparam lpc_regs_state_t RST = '{
    bc_sync1:     1'b0,
    bc_sync2:     1'b0,
    bc_sync3:     1'b0,
    link_up:      1'b0,
    dp_ctl:       `LPC_DP_CTL_RST,
    rsvd_a:       `LPC_RSVD_RST,
    cap:          `LPC_CAP_RST,
    rsvd_b:       `LPC_RSVD_RST,
    paddr:        {`LPC_PARTNER_ADR_RST, 1'b0},
    rsvd_c:       `LPC_RSVD_RST,
    tgt0:         `LPC_TGT_RST,
    tgt1:         `LPC_TGT_RST,
    rd_data:      8'h00,
    cs_state:     LPC_CS_DATA,
    cs_cnt:       3'h0,
    cs_crc_on:    1'b0,
    cs_ready:     1'b1,
    cs_out_valid: 1'b0,
    cs_out_byte:  8'h00,
    cs_out_crc:   1'b0,
    i2c_fwd:      1'b0,
    i2c_miss:     1'b0,
    i2c_fwd_addr: 7'h00
  };

  lpc_regs_state_t q;
  lpc_regs_state_t d;
  logic            crc_step;
  logic            crc_start;
  logic            crc_on_now;
  logic [7:0]      crc_val;
  logic            cs_take;
  logic            cap_wr;
  logic            adr_wr;

  lpc_crc8 u_crc (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .step_i    (crc_step),
    .start_i   (crc_start),
    .byte_i    (cs_byte_i),
    .crc_o     (crc_val)
  );

  assign cs_take    = cs_valid_i && q.cs_ready;
  // First byte samples the enable so a sequence never changes form midway
  assign crc_on_now = (q.cs_cnt == 3'h0) ? q.dp_ctl[`LPC_DP_CRC_EN_BIT] : q.cs_crc_on;
  assign cap_wr     = reg_wr_i && reg_addr_i == `LPC_OFF_PARTNER_CAP;
  assign adr_wr     = reg_wr_i && reg_addr_i == `LPC_OFF_PARTNER_ADR;

  always_comb begin
    d         = q;
    crc_step  = 1'b0;
    crc_start = 1'b0;

    // Back-channel link level: compare only the later two stages
    d.bc_sync1 = bc_link_i;
    d.bc_sync2 = q.bc_sync1;
    d.bc_sync3 = q.bc_sync2;
    if (q.bc_sync2 == q.bc_sync3) begin
      d.link_up = q.bc_sync3;
    end

    // Autoload, blocked while frozen; frozen fields keep what software wrote
    if (q.link_up && bc_cap_valid_i && !q.cap[`LPC_CAP_FREEZE_BIT]) begin
      d.cap[`LPC_CAP_SELFTEST]                   = bc_selftest_i;
      d.cap[`LPC_CAP_MULTI_PORT]                 = bc_multi_port_i;
      d.cap[`LPC_CAP_PORT_HI:`LPC_CAP_PORT_LO]   = bc_port_num_i;
    end
    if (q.link_up && bc_addr_valid_i && !q.paddr[`LPC_ADR_FREEZE_BIT]) begin
      d.paddr[7:1] = bc_partner_addr_i;
    end

    // Software write wins over an autoload in the same cycle
    if (reg_wr_i) begin
      case (reg_addr_i)
        `LPC_OFF_DP_CTL:      d.dp_ctl = reg_wdata_i;
        `LPC_OFF_RSVD_A:      d.rsvd_a = reg_wdata_i;
        `LPC_OFF_PARTNER_CAP: d.cap    = reg_wdata_i;
        `LPC_OFF_RSVD_B:      d.rsvd_b = reg_wdata_i;
        `LPC_OFF_PARTNER_ADR: d.paddr  = reg_wdata_i;
        `LPC_OFF_RSVD_C:      d.rsvd_c = reg_wdata_i;
        `LPC_OFF_TGT_ZERO:    d.tgt0   = reg_wdata_i[7:1];
        `LPC_OFF_TGT_ONE:     d.tgt1   = reg_wdata_i[7:1];
        default:              d.rd_data = d.rd_data;
      endcase
    end

    // Read data for one cycle only; unmapped reads return zero
    d.rd_data = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `LPC_OFF_DP_CTL:      d.rd_data = q.dp_ctl;
        `LPC_OFF_RSVD_A:      d.rd_data = q.rsvd_a;
        `LPC_OFF_PARTNER_CAP: d.rd_data = q.cap;
        `LPC_OFF_RSVD_B:      d.rd_data = q.rsvd_b;
        `LPC_OFF_PARTNER_ADR: d.rd_data = q.paddr;
        `LPC_OFF_RSVD_C:      d.rd_data = q.rsvd_c;
        `LPC_OFF_TGT_ZERO:    d.rd_data = {q.tgt0, 1'b0};
        `LPC_OFF_TGT_ONE:     d.rd_data = {q.tgt1, 1'b0};
        default:              d.rd_data = 8'h00;
      endcase
    end

    // Control sequence: eight data bytes, then optionally the CRC byte
    d.cs_out_valid = 1'b0;
    d.cs_out_crc   = 1'b0;
    unique case (q.cs_state)
      LPC_CS_DATA: begin
        if (cs_take) begin
          d.cs_out_valid = 1'b1;
          d.cs_out_byte  = cs_byte_i;
          crc_step       = 1'b1;
          crc_start      = q.cs_cnt == 3'h0;
          d.cs_crc_on    = crc_on_now;
          d.cs_cnt       = q.cs_cnt + 3'h1;
          if (q.cs_cnt == `LPC_CS_LAST_IDX && crc_on_now) begin
            d.cs_state = LPC_CS_CRC;
            d.cs_ready = 1'b0;
          end
        end
      end
      LPC_CS_CRC: begin
        d.cs_out_valid = 1'b1;
        d.cs_out_byte  = crc_val;
        d.cs_out_crc   = 1'b1;
        d.cs_state     = LPC_CS_DATA;
        d.cs_ready     = 1'b1;
      end
    endcase

    // Alias decode; an alias of zero is treated as unused
    d.i2c_fwd  = 1'b0;
    d.i2c_miss = 1'b0;
    if (i2c_req_i) begin
      if (pass_through_i && alias_zero_i != 7'h00 && i2c_addr_i == alias_zero_i) begin
        d.i2c_fwd      = 1'b1;
        d.i2c_fwd_addr = q.tgt0;
      end else if (pass_through_i && alias_one_i != 7'h00 && i2c_addr_i == alias_one_i) begin
        d.i2c_fwd      = 1'b1;
        d.i2c_fwd_addr = q.tgt1;
      end else begin
        d.i2c_miss = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o                = q.rd_data;
  assign bc_link_up_o               = q.link_up;
  assign cs_ready_o                 = q.cs_ready;
  assign cs_out_valid_o             = q.cs_out_valid;
  assign cs_out_byte_o              = q.cs_out_byte;
  assign cs_out_crc_o               = q.cs_out_crc;
  assign i2c_fwd_o                  = q.i2c_fwd;
  assign i2c_fwd_addr_o             = q.i2c_fwd_addr;
  assign i2c_miss_o                 = q.i2c_miss;
  assign ctrl_seq_crc_enable_o      = q.dp_ctl[`LPC_DP_CRC_EN_BIT];
  assign fwd_gpio_count_o           = q.dp_ctl[`LPC_DP_GPIO_HI:`LPC_DP_GPIO_LO];
  assign cap_freeze_o               = q.cap[`LPC_CAP_FREEZE_BIT];
  assign partner_selftest_request_o = q.cap[`LPC_CAP_SELFTEST];
  assign partner_multi_port_o       = q.cap[`LPC_CAP_MULTI_PORT];
  assign partner_port_num_o         = q.cap[`LPC_CAP_PORT_HI:`LPC_CAP_PORT_LO];
  assign partner_device_address_o   = q.paddr[7:1];
  assign partner_address_freeze_o   = q.paddr[`LPC_ADR_FREEZE_BIT];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence last_byte_crc_s;
    cs_take && q.cs_state == LPC_CS_DATA && q.cs_cnt == `LPC_CS_LAST_IDX && crc_on_now;
  endsequence

  sequence last_byte_plain_s;
    cs_take && q.cs_state == LPC_CS_DATA && q.cs_cnt == `LPC_CS_LAST_IDX && !crc_on_now;
  endsequence

  sequence crc_byte_out_s;
    ##1 (cs_out_valid_o && !cs_ready_o) ##1 (cs_out_valid_o && cs_out_crc_o && cs_ready_o);
  endsequence

  crc_ninth_byte_a: assert property (last_byte_crc_s |-> crc_byte_out_s)
    else $error("CRC byte did not follow the eighth byte");

  crc_disabled_a: assert property (last_byte_plain_s |=> cs_ready_o ##1 !cs_out_crc_o)
    else $error("CRC byte sent while disabled");

  crc_value_a: assert property (last_byte_crc_s ##1 1'b1 |=> cs_out_byte_o == $past(crc_val))
    else $error("CRC byte does not match running CRC");

  gpio_readback_a: assert property (reg_wr_i && reg_addr_i == `LPC_OFF_DP_CTL ##1 reg_rd_i
                                    && reg_addr_i == `LPC_OFF_DP_CTL && !reg_wr_i
                                    |=> reg_rdata_o[1:0] == $past(reg_wdata_i[1:0], 2))
    else $error("Forward GPIO count did not read back");

  cap_frozen_a: assert property (cap_freeze_o && !cap_wr |=> $stable(partner_port_num_o)
                                 && $stable(partner_multi_port_o) && $stable(partner_selftest_request_o))
    else $error("Frozen capabilities changed");

  cap_autoload_a: assert property (bc_link_up_o && bc_cap_valid_i && !cap_freeze_o && !cap_wr
                                   |=> partner_port_num_o == $past(bc_port_num_i)
                                   && partner_selftest_request_o == $past(bc_selftest_i)
                                   && partner_multi_port_o == $past(bc_multi_port_i))
    else $error("Capabilities not loaded from back channel");

  addr_frozen_a: assert property (partner_address_freeze_o && !adr_wr
                                  |=> $stable(partner_device_address_o))
    else $error("Frozen partner address changed");

  addr_autoload_a: assert property (bc_link_up_o && bc_addr_valid_i && !partner_address_freeze_o && !adr_wr
                                    |=> partner_device_address_o == $past(bc_partner_addr_i))
    else $error("Partner address not loaded");

  target_rsvd_a: assert property (reg_rd_i
                                  && (reg_addr_i == `LPC_OFF_TGT_ZERO || reg_addr_i == `LPC_OFF_TGT_ONE)
                                  |=> reg_rdata_o[0] == 1'b0)
    else $error("Target slot reserved bit reads one");

  alias_remap_a: assert property (i2c_req_i && pass_through_i && alias_zero_i != 7'h00
                                  && i2c_addr_i == alias_zero_i
                                  |=> i2c_fwd_o && i2c_fwd_addr_o == $past(q.tgt0))
    else $error("Alias zero not remapped");

  no_pass_a: assert property (i2c_req_i && !pass_through_i |=> !i2c_fwd_o && i2c_miss_o)
    else $error("Forwarded with pass-through off");

  rsvd_readback_a: assert property (reg_wr_i && reg_addr_i == `LPC_OFF_RSVD_B ##1 reg_rd_i
                                    && reg_addr_i == `LPC_OFF_RSVD_B && !reg_wr_i
                                    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("Reserved register did not read back");

endmodule

//--- inc/lpc_defs.svh
// Purpose: Offsets, field positions, reset values and constants of the link partner config bank
// Assumes: 8-bit register address and data
// Notes:   Included by the design modules and the testbench
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH

`define LPC_OFF_DP_CTL      8'h33
`define LPC_OFF_RSVD_A      8'h34
`define LPC_OFF_PARTNER_CAP 8'h35
`define LPC_OFF_RSVD_B      8'h36
`define LPC_OFF_PARTNER_ADR 8'h37
`define LPC_OFF_RSVD_C      8'h38
`define LPC_OFF_TGT_ZERO    8'h39
`define LPC_OFF_TGT_ONE     8'h3A

`define LPC_DP_CRC_EN_BIT   2
`define LPC_DP_GPIO_HI      1
`define LPC_DP_GPIO_LO      0
`define LPC_CAP_FREEZE_BIT  7
`define LPC_CAP_SELFTEST    5
`define LPC_CAP_MULTI_PORT  4
`define LPC_CAP_PORT_HI     3
`define LPC_CAP_PORT_LO     0
`define LPC_ADR_FREEZE_BIT  0

`define LPC_DP_CTL_RST      8'h04
`define LPC_CAP_RST         8'h00
`define LPC_RSVD_RST        8'h00
`define LPC_TGT_RST         7'h00
// Arbitrary neutral partner address at reset
`define LPC_PARTNER_ADR_RST 7'h2A

// Bytes covered by the CRC; the CRC itself goes out as the next byte
`define LPC_CS_DATA_BYTES   4'h8
`define LPC_CS_LAST_IDX     3'h7
`define LPC_CRC_POLY        8'h07
`define LPC_CRC_INIT        8'h00

`endif

//--- inc/lpc_pkg.sv
// Purpose: Types of the link partner config bank
// Assumes: lpc_defs.svh carries the numbers
// Notes:   State of each design module is one packed struct
package lpc_pkg;

  typedef enum logic [0:0] {
    LPC_CS_DATA,
    LPC_CS_CRC
  } lpc_cs_state_t;

  typedef struct packed {
    logic          bc_sync1;
    logic          bc_sync2;
    logic          bc_sync3;
    logic          link_up;
    logic [7:0]    dp_ctl;
    logic [7:0]    rsvd_a;
    logic [7:0]    cap;
    logic [7:0]    rsvd_b;
    logic [7:0]    paddr;
    logic [7:0]    rsvd_c;
    logic [6:0]    tgt0;
    logic [6:0]    tgt1;
    logic [7:0]    rd_data;
    lpc_cs_state_t cs_state;
    logic [2:0]    cs_cnt;
    logic          cs_crc_on;
    logic          cs_ready;
    logic          cs_out_valid;
    logic [7:0]    cs_out_byte;
    logic          cs_out_crc;
    logic          i2c_fwd;
    logic          i2c_miss;
    logic [6:0]    i2c_fwd_addr;
  } lpc_regs_state_t;

  typedef struct packed {
    logic [7:0] crc;
  } lpc_crc_state_t;

endpackage

//--- verilog/lpc_crc8.sv
// Purpose: Running CRC-8 over the bytes of one control sequence
// Assumes: One byte per step; start restarts from the init value
// Notes:   Result is valid the cycle after the last step
`timescale 1ns/1ps
`include "lpc_defs.svh"

module lpc_crc8 (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       step_i,
  input  wire logic       start_i,
  input  wire logic [7:0] byte_i,
  output logic [7:0]      crc_o
);
  import lpc_pkg::*;

  lpc_crc_state_t q;
  lpc_crc_state_t d;
  logic [7:0]     acc;

  always_comb begin
    d   = q;
    acc = (start_i ? `LPC_CRC_INIT : q.crc) ^ byte_i;
    for (int i = 0; i < 8; i++) begin
      acc = acc[7] ? ((acc << 1) ^ `LPC_CRC_POLY) : (acc << 1);
    end
    if (step_i) begin
      d.crc = acc;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{crc: `LPC_CRC_INIT};
    end else begin
      q <= d;
    end
  end

  assign crc_o = q.crc;

  crc_restart_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    step_i && start_i && byte_i == 8'h00 |=> crc_o == `LPC_CRC_INIT)
    else $error("CRC did not restart from init");

  // Idle cycles between bytes must not disturb the running value
  crc_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !step_i |=> $stable(crc_o))
    else $error("CRC changed without a step");

endmodule

//--- verif/lpc_partner.sv
// Purpose: Remote deserializer model driving the back-channel inputs
// Assumes: Testbench calls its tasks; changes land just after a rising edge
// Notes:   Fields carry inverted junk outside a load pulse, never the last value
`timescale 1ns/1ps

module lpc_partner (
  input  wire logic       sys_clk_i,
  output logic            bc_link_o,
  output logic            bc_cap_valid_o,
  output logic            bc_selftest_o,
  output logic            bc_multi_port_o,
  output logic [3:0]      bc_port_num_o,
  output logic            bc_addr_valid_o,
  output logic [6:0]      bc_partner_addr_o
);
  initial begin
    {bc_link_o, bc_cap_valid_o, bc_selftest_o, bc_multi_port_o, bc_port_num_o} = 8'h00;
    {bc_addr_valid_o, bc_partner_addr_o} = 8'h00;
  end

  task automatic set_link(input logic v);
    @(posedge sys_clk_i);
    bc_link_o <= v;
  endtask

  // One-cycle load of the capability fields
  task automatic send_cap(input logic st, input logic mp, input logic [3:0] pn);
    @(posedge sys_clk_i);
    {bc_cap_valid_o, bc_selftest_o, bc_multi_port_o, bc_port_num_o} <= {1'h1, st, mp, pn};
    @(posedge sys_clk_i);
    {bc_cap_valid_o, bc_selftest_o, bc_multi_port_o, bc_port_num_o} <= {1'h0, ~st, ~mp, ~pn};
  endtask

  task automatic send_addr(input logic [6:0] a);
    @(posedge sys_clk_i);
    {bc_addr_valid_o, bc_partner_addr_o} <= {1'h1, a};
    @(posedge sys_clk_i);
    {bc_addr_valid_o, bc_partner_addr_o} <= {1'h0, ~a};
  endtask
endmodule

//--- verif/testbench.sv
// Purpose: Self-checking bench of lpc_regs against a register model
// Assumes: Read data stand only in the cycle after the read strobe
// Notes:   Partner model supplies the back-channel loads
`timescale 1ns/1ps
`include "lpc_defs.svh"
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end

module testbench;
  logic       sys_clk_i = 1'h0;
  logic       rst_i = 1'h1;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, cs_byte_i = 8'h00, reg_rdata_o, cs_out_byte_o;
  logic       reg_wr_i = 1'h0, reg_rd_i = 1'h0, cs_valid_i = 1'h0, pass_through_i = 1'h0, i2c_req_i = 1'h0;
  logic [6:0] alias_zero_i = 7'h00, alias_one_i = 7'h00, i2c_addr_i = 7'h00;
  logic [6:0] i2c_fwd_addr_o, partner_device_address_o, bc_partner_addr_i;
  logic [3:0] partner_port_num_o, bc_port_num_i;
  logic [1:0] fwd_gpio_count_o;
  logic       bc_link_i, bc_cap_valid_i, bc_selftest_i, bc_multi_port_i, bc_addr_valid_i, bc_link_up_o;
  logic       cs_ready_o, cs_out_valid_o, cs_out_crc_o, i2c_fwd_o, i2c_miss_o, ctrl_seq_crc_enable_o;
  logic       cap_freeze_o, partner_selftest_request_o, partner_multi_port_o, partner_address_freeze_o;
  int         errors = 0, total_checks = 0, cycles = 0, seed = 30072;
  logic [7:0] mdl [8'h33:8'h3A];
  logic [7:0] dq[$], cq[$], sent[$];
  logic [6:0] pa;

  lpc_regs dut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .bc_link_i, .bc_cap_valid_i, .bc_selftest_i, .bc_multi_port_i, .bc_port_num_i, .bc_addr_valid_i,
    .bc_partner_addr_i, .bc_link_up_o, .cs_valid_i, .cs_byte_i, .cs_ready_o, .cs_out_valid_o,
    .cs_out_byte_o, .cs_out_crc_o, .pass_through_i, .alias_zero_i, .alias_one_i, .i2c_req_i, .i2c_addr_i,
    .i2c_fwd_o, .i2c_fwd_addr_o, .i2c_miss_o, .ctrl_seq_crc_enable_o, .fwd_gpio_count_o, .cap_freeze_o,
    .partner_selftest_request_o, .partner_multi_port_o, .partner_port_num_o, .partner_device_address_o,
    .partner_address_freeze_o);

  lpc_partner partner (.sys_clk_i, .bc_link_o(bc_link_i), .bc_cap_valid_o(bc_cap_valid_i),
    .bc_selftest_o(bc_selftest_i), .bc_multi_port_o(bc_multi_port_i), .bc_port_num_o(bc_port_num_i),
    .bc_addr_valid_o(bc_addr_valid_i), .bc_partner_addr_o(bc_partner_addr_i));

  always #2 sys_clk_i = ~sys_clk_i;

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  always @(posedge sys_clk_i) begin
    if (cs_out_crc_o === 1'h1) cq.push_back(cs_out_byte_o);
    else if (cs_out_valid_o === 1'h1) dq.push_back(cs_out_byte_o);
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'h1, a, d};
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h0;
    if (a >= 8'h33 && a <= 8'h3A) mdl[a] = (a >= `LPC_OFF_TGT_ZERO) ? {d[7:1], 1'h0} : d;
  endtask

  task automatic rd_chk(input logic [7:0] a);
    @(posedge sys_clk_i);
    rd_go(a);
  endtask

  // Starts in the current edge's time step, so it may follow a write with no gap
  task automatic rd_go(input logic [7:0] a);
    logic [7:0] e;
    e = (a >= 8'h33 && a <= 8'h3A) ? mdl[a] : 8'h00;
    {reg_rd_i, reg_addr_i} <= {1'h1, a};
    @(posedge sys_clk_i);
    reg_rd_i <= 1'h0;
    #1;
    `CHK("rdata", e, reg_rdata_o)
  endtask

  task automatic cfg_chk();
    `CHK("crc_en", mdl[8'h33][2], ctrl_seq_crc_enable_o)
    `CHK("gpio", mdl[8'h33][1:0], fwd_gpio_count_o)
    `CHK("selftest", mdl[8'h35][5], partner_selftest_request_o)
    `CHK("multi_port", mdl[8'h35][4], partner_multi_port_o)
    `CHK("port", mdl[8'h35][3:0], partner_port_num_o)
    `CHK("cap_frz", mdl[8'h35][7], cap_freeze_o)
    `CHK("paddr", mdl[8'h37][7:1], partner_device_address_o)
    `CHK("adr_frz", mdl[8'h37][0], partner_address_freeze_o)
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] q[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) begin
      c ^= q[i];
      repeat (8) c = c[7] ? ({c[6:0], 1'h0} ^ 8'h07) : {c[6:0], 1'h0};
    end
    return c;
  endfunction

  // Eight bytes, each held until the design shows ready
  task automatic send_seq(input logic crc_on);
    sent = {};
    dq = {};
    cq = {};
    @(posedge sys_clk_i);
    repeat (8) begin
      // A zero opening byte without CRC exercises the restart from init
      sent.push_back((sent.size() == 0 && !crc_on) ? 8'h00 : 8'($random(seed)));
      cs_valid_i <= 1'h1;
      cs_byte_i <= sent[$];
      #1;
      while (cs_ready_o !== 1'h1) begin
        @(posedge sys_clk_i);
        #1;
      end
      @(posedge sys_clk_i);
    end
    cs_valid_i <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    `CHK("n_data", 8, dq.size())
    foreach (sent[i]) `CHK("data", sent[i], dq[i])
    `CHK("n_crc", crc_on ? 1 : 0, cq.size())
    if (crc_on) `CHK("crc", crc8(sent), cq[0])
  endtask

  task automatic i2c(input logic [6:0] a, input logic f, input logic [6:0] e);
    @(posedge sys_clk_i);
    {i2c_req_i, i2c_addr_i} <= {1'h1, a};
    @(posedge sys_clk_i);
    i2c_req_i <= 1'h0;
    #1;
    `CHK("fwd", f, i2c_fwd_o)
    `CHK("miss", ~f, i2c_miss_o)
    if (f) `CHK("fwd_addr", e, i2c_fwd_addr_o)
  endtask

  initial begin
    foreach (mdl[a]) mdl[a] = 8'h00;
    mdl[8'h33] = 8'h04;
    mdl[8'h37] = {`LPC_PARTNER_ADR_RST, 1'h0};
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    for (int a = 8'h32; a <= 8'h3B; a++) rd_chk(8'(a));
    rd_chk(8'hFF);
    cfg_chk();
    $display("test reset done");

    partner.set_link(1'h1);
    repeat (8) @(posedge sys_clk_i);
    `CHK("link_up", 1'h1, bc_link_up_o)
    pa = 7'($random(seed));
    partner.send_cap(pa[0], pa[1], pa[5:2]);
    mdl[8'h35][5:0] = {pa[0], pa[1], pa[5:2]};
    #1;
    cfg_chk();
    wr(8'h35, {1'h1, 1'h0, ~pa[5:0]});
    partner.send_cap(pa[0], pa[1], pa[5:2]);
    #1;
    cfg_chk();
    rd_chk(8'h35);
    partner.send_addr(pa);
    mdl[8'h37][7:1] = pa;
    #1;
    cfg_chk();
    wr(8'h37, {~pa, 1'h1});
    partner.send_addr(pa);
    #1;
    cfg_chk();
    rd_chk(8'h37);
    $display("test back channel done");

    for (int a = 8'h33; a <= 8'h3A; a++) begin
      wr(8'(a), 8'($random(seed)));
      rd_go(8'(a));
    end
    wr(8'h3B, 8'($random(seed)));
    rd_go(8'h3B);
    for (int a = 8'h33; a <= 8'h3A; a++) rd_chk(8'(a));
    for (int g = 0; g < 4; g++) begin
      wr(8'h33, {5'h1F, 1'h1, 2'(g)});
      #1;
      cfg_chk();
    end
    rd_chk(8'h33);
    $display("test register access done");

    send_seq(1'h1);
    wr(8'h33, 8'h00);
    send_seq(1'h0);
    $display("test control sequence done");

    wr(`LPC_OFF_TGT_ZERO, 8'($random(seed)));
    wr(`LPC_OFF_TGT_ONE, 8'($random(seed)));
    alias_zero_i <= 7'h11;
    alias_one_i <= 7'h22;
    pass_through_i <= 1'h1;
    i2c(7'h11, 1'h1, mdl[8'h39][7:1]);
    i2c(7'h22, 1'h1, mdl[8'h3A][7:1]);
    i2c(7'h33, 1'h0, 7'h00);
    pass_through_i <= 1'h0;
    i2c(7'h11, 1'h0, 7'h00);
    $display("test i2c remap done");
    tally_and_finish();
  end
endmodule
